// File: bench/dcl_debug_ctrl_tb.sv
// Purpose: self-checking bench for the debug control lower fields
// Assumes: 100 ns clock, host model drives the register port
// Notes:   comb outputs are sampled 1 ns after the falling-edge drive
`timescale 1ns/1ps
`include "dcl_consts.svh"
`default_nettype none
module dcl_debug_ctrl_tb;
    logic        clk_sys, rstn, cfg_wr, resume_cmd, bde;
    logic        done, is_halt, sup, irq, xfer;
    logic        bwr, br, pch, adh;
    logic [1:0]  bsz;
    logic [31:0] wdata, bdata, btgt, rdata;
    logic        ok, ill, hx, itk, brep, hlt, dbg, tclk, tbusy;
    logic [3:0]  tnib;
    int          err_count = 0, comparisons = 0;
    always #50 clk_sys = ~clk_sys;
    dcl_host_model HOST (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_wdata(wdata),
        .resume_cmd(resume_cmd));
    dcl_debug_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .cfg_wr(cfg_wr),
        .cfg_wdata(wdata), .cfg_rdata(rdata), .resume_cmd(resume_cmd),
        .background_debug_enable(bde), .insn_done(done), .insn_is_halt(is_halt),
        .supervisor(sup), .irq_pending(irq), .bus_xfer(xfer), .bus_write(bwr),
        .bus_size(bsz), .bus_data(bdata), .branch_taken(br), .branch_target(btgt),
        .pc_bkpt_hit(pch), .ad_bkpt_hit(adh), .insn_start_ok(ok),
        .halt_illegal(ill), .halt_exec(hx), .irq_take(itk), .bkpt_report(brep),
        .core_halted(hlt), .dbg_mode_out(dbg), .trace_clock(tclk),
        .trace_data_bus(tnib), .trace_busy(tbusy));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one retiring instruction; the halt flag qualifies it
    task automatic pulse_done(input logic h);
        @(negedge clk_sys);
        done = 1'b1;
        is_halt = h;
        #1;
        @(negedge clk_sys);
        done = 1'b0;
        is_halt = 1'b0;
    endtask
    task automatic t_regs();
        check(rdata, `DCL_RESET_VAL);
        // one edge after release the trace clock has toggled high
        check({ok, dbg, hlt, tclk}, 4'h9);
        HOST.write_cfg(32'hffff_ffff);
        check(rdata, `DCL_WR_MASK);
        HOST.write_cfg(32'h0000_0002);
        @(negedge clk_sys);
        check(dbg, 1'b1);
        HOST.write_cfg(32'h0000_0000);
        @(negedge clk_sys);
        check(dbg, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_step();
        HOST.write_cfg(32'h0000_0010);
        pulse_done(1'b0);
        check(hlt, 1'b1);
        @(negedge clk_sys);
        check(dbg, 1'b1);
        HOST.write_cfg(32'h0000_0011);
        @(negedge clk_sys);
        check(dbg, 1'b0);
        HOST.resume();
        check(hlt, 1'b0);
        pulse_done(1'b0);
        check(hlt, 1'b1);
        HOST.write_cfg(32'h0000_0000);
        HOST.resume();
        pulse_done(1'b0);
        check(hlt, 1'b0);
        $display("test step done");
    endtask
    // irq seen while waiting for the stepped instruction
    task automatic t_irq();
        irq = 1'b1;
        HOST.write_cfg(32'h0000_0030);
        pulse_done(1'b0);
        HOST.resume();
        #1;
        check(itk, 1'b0);
        HOST.write_cfg(32'h0000_0010);
        #1;
        check(itk, 1'b1);
        irq = 1'b0;
        pulse_done(1'b0);
        HOST.write_cfg(32'h0000_0000);
        HOST.resume();
        $display("test irq done");
    endtask
    // every mix of enable, privilege and user allow
    task automatic t_halt();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            HOST.write_cfg({21'h0, c[0], 10'h0});
            @(negedge clk_sys);
            bde = c[2];
            sup = c[1];
            done = 1'b1;
            is_halt = 1'b1;
            #1;
            check({ill, hx}, (c[2] && (c[1] || c[0])) ? 2'h1 : 2'h2);
            @(negedge clk_sys);
            done = 1'b0;
            is_halt = 1'b0;
            HOST.resume();
        end
        bde = 1'b0;
        $display("test halt done");
    endtask
    // trigger lands with a retire so only the pending report can hold the start
    task automatic t_bkpt();
        HOST.write_cfg(32'h0000_0040);
        check(ok, 1'b0);
        @(negedge clk_sys);
        done = 1'b1;
        adh = 1'b1;
        #1;
        check(brep, 1'b1);
        @(negedge clk_sys);
        done = 1'b0;
        adh = 1'b0;
        check({brep, ok}, 2'h2);
        @(negedge clk_sys);
        check(ok, 1'b1);
        HOST.write_cfg(32'h0000_0000);
        pch = 1'b1;
        #1;
        check({brep, ok}, 2'h2);
        @(negedge clk_sys);
        pch = 1'b0;
        check(hlt, 1'b1);
        HOST.resume();
        $display("test bkpt done");
    endtask
    // reset in mid-run drops the fields and the forced indication
    task automatic t_reset();
        HOST.write_cfg(32'h0000_0012);
        @(negedge clk_sys);
        check(dbg, 1'b1);
        rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(rdata, `DCL_RESET_VAL);
        check({ok, dbg, hlt}, 3'h4);
        rstn = 1'b1;
        @(negedge clk_sys);
        check(rdata, `DCL_RESET_VAL);
        check({ok, dbg, hlt}, 3'h4);
        $display("test reset done");
    endtask
    // events only land on a high trace_clock edge with the trace idle
    task automatic launch(input logic b, input logic w, input logic [1:0] s,
                          input logic [31:0] d);
        @(negedge clk_sys);
        while (tclk !== 1'b1 || tbusy !== 1'b0)
            @(negedge clk_sys);
        br = b;
        xfer = ~b;
        bwr = w;
        bsz = s;
        bdata = d;
        btgt = d;
        @(negedge clk_sys);
        br = 1'b0;
        xfer = 1'b0;
        bdata = ~d;
        btgt = ~d;
    endtask
    task automatic trace_seq(input logic [3:0] m, input logic [31:0] v, input int n);
        int k;
        k = 0;
        while (tnib !== m && k < 8) begin
            @(negedge clk_sys);
            k++;
        end
        check(tnib, m);
        for (int j = 0; j < n; j++) begin
            repeat (2) @(negedge clk_sys);
            check(tnib, v[4*j +: 4]);
        end
    endtask
    task automatic t_trace();
        HOST.write_cfg(32'h0000_0900);
        launch(1'b0, 1'b1, 2'h2, 32'h1234_5678);
        trace_seq(`DCL_MARK_LONG, 32'h1234_5678, 8);
        launch(1'b0, 1'b0, 2'h0, 32'h0000_00c3);
        repeat (4) @(negedge clk_sys);
        check(tbusy, 1'b0);
        launch(1'b1, 1'b0, 2'h0, 32'h00ab_cdef);
        trace_seq(`DCL_MARK_TGT2, 32'h00ab_cdef, 4);
        HOST.write_cfg(32'h0000_1200);
        launch(1'b0, 1'b0, 2'h0, 32'h0000_00c3);
        trace_seq(`DCL_MARK_BYTE, 32'h0000_00c3, 2);
        launch(1'b1, 1'b0, 2'h0, 32'h0012_3456);
        trace_seq(`DCL_MARK_TGT3, 32'h0012_3456, 6);
        HOST.write_cfg(32'h0000_1b00);
        launch(1'b0, 1'b1, 2'h1, 32'h0000_beef);
        trace_seq(`DCL_MARK_WORD, 32'h0000_beef, 4);
        launch(1'b1, 1'b0, 2'h0, 32'h0065_4321);
        trace_seq(`DCL_MARK_TGT3, 32'h0065_4321, 6);
        HOST.write_cfg(32'h0000_0000);
        launch(1'b1, 1'b0, 2'h0, 32'h0000_1111);
        repeat (4) @(negedge clk_sys);
        check(tbusy, 1'b0);
        $display("test trace done");
    endtask
    // cut a hang short well past the expected run time
    initial begin
        #500_000;
        err_count++;
        finish_test();
    end
    initial begin
        clk_sys = 1'b0;
        rstn    = 1'b0;
        bde     = 1'b0;
        done    = 1'b0;
        is_halt = 1'b0;
        sup     = 1'b0;
        irq     = 1'b0;
        xfer    = 1'b0;
        bwr     = 1'b0;
        br      = 1'b0;
        pch     = 1'b0;
        adh     = 1'b0;
        bsz     = 2'h0;
        bdata   = 32'h0000_0000;
        btgt    = 32'h0000_0000;
        repeat (4) @(negedge clk_sys);
        // while reset is held only the start permission is high
        check({ok, dbg, hlt, tclk}, 4'h8);
        rstn = 1'b1;
        @(negedge clk_sys);
        t_regs();
        t_step();
        t_irq();
        t_halt();
        t_bkpt();
        t_trace();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire

// File: bench/dcl_host_model.sv
// Purpose: debug host model on the background debug port
// Assumes: whole 32-bit writes, one-cycle strobes
// Notes:   drives on the falling edge so rising-edge sampling is clean
`timescale 1ns/1ps
`default_nettype none
module dcl_host_model (
    input  wire logic        clk_sys,
    output logic             cfg_wr,
    output logic      [31:0] cfg_wdata,
    output logic             resume_cmd
);
    // idle values from time zero
    initial begin
        cfg_wr     = 1'b0;
        cfg_wdata  = 32'h0000_0000;
        resume_cmd = 1'b0;
    end
    // data inverted after the strobe so stale data never looks valid
    task automatic write_cfg(input logic [31:0] v);
        @(negedge clk_sys);
        cfg_wr    = 1'b1;
        cfg_wdata = v;
        @(negedge clk_sys);
        cfg_wr    = 1'b0;
        cfg_wdata = ~v;
    endtask
    // one resume releases exactly one more instruction when stepping
    task automatic resume();
        @(negedge clk_sys);
        resume_cmd = 1'b1;
        @(negedge clk_sys);
        resume_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: hdl/dcl_consts.svh
// Purpose: constants for the debug control lower fields block
// Assumes: register word is 32 bits, fields live in bits 12..0
// Notes:   values are bit positions, the write mask, the reset value and trace marker nibbles
`ifndef DCL_CONSTS_SVH
`define DCL_CONSTS_SVH

`define DCL_OPC_HI       12
`define DCL_OPC_LO       11
`define DCL_UHALT_BIT    10
`define DCL_TGT_HI       9
`define DCL_TGT_LO       8
`define DCL_NOPIPE_BIT   6
`define DCL_IRQIGN_BIT   5
`define DCL_STEP_BIT     4
`define DCL_FORCE_BIT    1
`define DCL_HDIS_BIT     0
`define DCL_WR_MASK      32'h0000_1f73
`define DCL_RESET_VAL    32'h0000_0000
`define DCL_MARK_BYTE    4'h8
`define DCL_MARK_WORD    4'h9
`define DCL_MARK_LONG    4'ha
`define DCL_MARK_TGT2    4'hb
`define DCL_MARK_TGT3    4'hc

`endif

// File: hdl/dcl_debug_ctrl.sv
// Purpose: lower configuration fields and their control effects
// Assumes: register written over the background debug port write strobe, read back without a strobe
// Notes:   trace path runs on clk_sys; trace_clock is a divided copy
`timescale 1ns/1ps
`include "dcl_consts.svh"
`default_nettype none
module dcl_debug_ctrl
    import dcl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // background debug port register access
    input  wire logic        cfg_wr,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    input  wire logic        resume_cmd,
    input  wire logic        background_debug_enable,
    // core interface
    input  wire logic        insn_done,
    input  wire logic        insn_is_halt,
    input  wire logic        supervisor,
    input  wire logic        irq_pending,
    input  wire logic        bus_xfer,
    input  wire logic        bus_write,
    input  wire logic [1:0]  bus_size,
    input  wire logic [31:0] bus_data,
    input  wire logic        branch_taken,
    input  wire logic [31:0] branch_target,
    input  wire logic        pc_bkpt_hit,
    input  wire logic        ad_bkpt_hit,
    output logic             insn_start_ok,
    output logic             halt_illegal,
    output logic             halt_exec,
    output logic             irq_take,
    output logic             bkpt_report,
    output logic             core_halted,
    output logic             dbg_mode_out,
    output logic             trace_clock,
    output logic      [3:0]  trace_data_bus,
    output logic             trace_busy
);
    logic [31:0] cfg_q;
    logic [1:0]  operand_capture_sel;
    logic [1:0]  branch_target_bytes;
    logic        user_halt_allow, no_pipeline, step_irq_ignore, single_step_en;
    logic        force_dbg_out, halt_dbg_out_disable;
    dcl_core_e   core_q;
    logic        ad_pend_q;
    logic        run_q;

    // ------------------------------------------------------------
    // register and field decode
    // ------------------------------------------------------------
    // reserved bits are masked so they always read zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cfg_q <= `DCL_RESET_VAL;
        end else if (cfg_wr) begin
            cfg_q <= cfg_wdata & `DCL_WR_MASK;
        end
    end

    assign operand_capture_sel  = cfg_q[`DCL_OPC_HI:`DCL_OPC_LO];
    assign user_halt_allow      = cfg_q[`DCL_UHALT_BIT];
    assign branch_target_bytes  = cfg_q[`DCL_TGT_HI:`DCL_TGT_LO];
    assign no_pipeline          = cfg_q[`DCL_NOPIPE_BIT];
    assign step_irq_ignore      = cfg_q[`DCL_IRQIGN_BIT];
    assign single_step_en       = cfg_q[`DCL_STEP_BIT];
    assign force_dbg_out        = cfg_q[`DCL_FORCE_BIT];
    assign halt_dbg_out_disable = cfg_q[`DCL_HDIS_BIT];
    assign cfg_rdata            = cfg_q;

    // ------------------------------------------------------------
    // halt instruction privilege
    // ------------------------------------------------------------
    // illegal opcode wins over privilege: without enable no mode may halt
    assign halt_illegal = insn_done && insn_is_halt &&
        (!background_debug_enable || (!supervisor && !user_halt_allow));
    assign halt_exec    = insn_done && insn_is_halt && !halt_illegal;

    // ------------------------------------------------------------
    // execution state: run, step, halt
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            core_q <= DCL_RUN;
        end else begin
            case (core_q)
                DCL_RUN: begin
                    if (halt_exec || pc_bkpt_hit ||
                        (insn_done && single_step_en)) begin
                        core_q <= DCL_HALTED;
                    end
                end
                DCL_HALTED: begin
                    if (resume_cmd) begin
                        core_q <= single_step_en ? DCL_STEP_WAIT : DCL_RUN;
                    end
                end
                DCL_STEP_WAIT: begin
                    if (insn_done) begin
                        core_q <= single_step_en ? DCL_HALTED : DCL_RUN;
                    end
                end
                default: core_q <= DCL_RUN;
            endcase
        end
    end
    assign core_halted = (core_q == DCL_HALTED);

    // no overlap when no_pipeline is set: next instruction waits for the previous one to retire
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            run_q <= 1'b0;
        end else if (insn_done) begin
            run_q <= 1'b0;
        end else if (insn_start_ok) begin
            run_q <= 1'b1;
        end
    end
    assign insn_start_ok = !core_halted && !pc_bkpt_hit && !ad_pend_q &&
        (!no_pipeline || !run_q);

    // pipelined mode lets the trigger slip; non-pipelined holds the next start
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ad_pend_q <= 1'b0;
        end else begin
            ad_pend_q <= ad_bkpt_hit && no_pipeline;
        end
    end
    assign bkpt_report = pc_bkpt_hit || ad_bkpt_hit || ad_pend_q;

    // interrupts in step mode obey the ignore bit
    assign irq_take = irq_pending && !core_halted &&
        !(single_step_en && step_irq_ignore);

    // debug mode indication to other modules
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dbg_mode_out <= 1'b0;
        end else begin
            dbg_mode_out <= force_dbg_out ||
                ((core_q == DCL_HALTED) && !halt_dbg_out_disable);
        end
    end

    // ------------------------------------------------------------
    // trace serialiser: marker nibble, then data low nibble first
    // ------------------------------------------------------------
    dcl_trace_e  tr_q;
    logic [31:0] tr_data_q;
    logic [3:0]  tr_cnt_q;
    logic [3:0]  tr_mark_q;
    logic        tr_div_q;
    logic        cap_op, cap_br;

    function automatic logic [3:0] size_nibbles(input logic [1:0] sz);
        case (sz)
            2'h0:    size_nibbles = 4'h2;
            2'h1:    size_nibbles = 4'h4;
            default: size_nibbles = 4'h8;
        endcase
    endfunction

    assign cap_op = bus_xfer && ((bus_write && operand_capture_sel[0]) ||
        (!bus_write && operand_capture_sel[1]));
    assign cap_br = branch_taken && (branch_target_bytes != 2'h0);

    // one nibble per trace clock period (two system cycles); busy drops new events
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tr_div_q <= 1'b0;
        end else begin
            tr_div_q <= !tr_div_q;
        end
    end
    assign trace_clock = tr_div_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tr_q           <= DCL_TR_IDLE;
            tr_data_q      <= 32'h0000_0000;
            tr_cnt_q       <= 4'h0;
            tr_mark_q      <= 4'h0;
            trace_data_bus <= 4'h0;
        end else if (tr_div_q) begin
            case (tr_q)
                DCL_TR_IDLE: begin
                    trace_data_bus <= 4'h0;
                    if (cap_op) begin
                        tr_data_q <= bus_data;
                        tr_cnt_q  <= size_nibbles(bus_size);
                        tr_mark_q <= (bus_size == 2'h0) ? `DCL_MARK_BYTE :
                                     (bus_size == 2'h1) ? `DCL_MARK_WORD : `DCL_MARK_LONG;
                        tr_q      <= DCL_TR_MARK;
                    end else if (cap_br) begin
                        tr_data_q <= branch_target;
                        tr_cnt_q  <= branch_target_bytes[1] ? 4'h6 : 4'h4;
                        tr_mark_q <= branch_target_bytes[1] ? `DCL_MARK_TGT3 : `DCL_MARK_TGT2;
                        tr_q      <= DCL_TR_MARK;
                    end
                end
                DCL_TR_MARK: begin
                    trace_data_bus <= tr_mark_q;
                    tr_q           <= DCL_TR_DATA;
                end
                DCL_TR_DATA: begin
                    trace_data_bus <= tr_data_q[3:0];
                    tr_data_q      <= {4'h0, tr_data_q[31:4]};
                    tr_cnt_q       <= tr_cnt_q - 4'h1;
                    if (tr_cnt_q == 4'h1) begin
                        tr_q <= DCL_TR_IDLE;
                    end
                end
                default: tr_q <= DCL_TR_IDLE;
            endcase
        end
    end
    assign trace_busy = (tr_q != DCL_TR_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_dbg_out_eq: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 dbg_mode_out == ($past(force_dbg_out) ||
            ($past(core_halted) && !$past(halt_dbg_out_disable))))
        else $error("debug indication mismatch");
    a_force_dbg: assert property (@(posedge clk_sys) disable iff (!rstn)
        force_dbg_out |=> dbg_mode_out) else $error("force not shown");
    a_halt_dis: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!force_dbg_out && halt_dbg_out_disable) |=> !dbg_mode_out)
        else $error("halt disable ignored");
    a_halt_noen: assert property (@(posedge clk_sys) disable iff (!rstn)
        (insn_done && insn_is_halt && !background_debug_enable) |-> halt_illegal)
        else $error("halt without enable");
    a_halt_user: assert property (@(posedge clk_sys) disable iff (!rstn)
        (insn_done && insn_is_halt && !supervisor && !user_halt_allow) |-> !halt_exec)
        else $error("user halt allowed");
    a_step_halt: assert property (@(posedge clk_sys) disable iff (!rstn)
        (core_q == DCL_STEP_WAIT && insn_done && single_step_en) |=> core_halted)
        else $error("step did not halt");
    a_pc_bkpt: assert property (@(posedge clk_sys) disable iff (!rstn)
        pc_bkpt_hit |-> (bkpt_report && !insn_start_ok)) else $error("pc bkpt late");
    a_nopipe_prec: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ad_bkpt_hit && no_pipeline) |=> !insn_start_ok) else $error("imprecise");
    a_nopipe_overlap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (no_pipeline && run_q && !insn_done) |-> !insn_start_ok)
        else $error("overlap without pipeline");
    a_irq_ign: assert property (@(posedge clk_sys) disable iff (!rstn)
        (single_step_en && step_irq_ignore) |-> !irq_take) else $error("irq taken");
    a_no_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
        (operand_capture_sel == 2'h0) |-> !cap_op) else $error("capture off");
    a_mark_first: assert property (@(posedge clk_sys) disable iff (!rstn)
        (tr_div_q && tr_q == DCL_TR_MARK) |=> trace_data_bus == $past(tr_mark_q))
        else $error("marker missing");
    a_target_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        (branch_target_bytes == 2'h0) |-> !cap_br) else $error("target traced");

    c_step: cover property (@(posedge clk_sys) core_q == DCL_STEP_WAIT ##[1:20] core_halted);
    c_trace: cover property (@(posedge clk_sys) tr_q == DCL_TR_MARK ##[1:4] tr_q == DCL_TR_DATA);
    c_halt: cover property (@(posedge clk_sys) halt_exec);
    c_force: cover property (@(posedge clk_sys) dbg_mode_out && !core_halted);
endmodule
`default_nettype wire

// File: hdl/dcl_pkg.sv
// Purpose: types for the debug control lower fields block
// Assumes: none
// Notes:   size codes match the operand reference size
package dcl_pkg;
    typedef enum logic [1:0] {DCL_SZ_BYTE, DCL_SZ_WORD, DCL_SZ_LONG} dcl_size_e;
    typedef enum {DCL_RUN, DCL_STEP_WAIT, DCL_HALTED} dcl_core_e;
    typedef enum {DCL_TR_IDLE, DCL_TR_MARK, DCL_TR_DATA} dcl_trace_e;
endpackage
